// File: rtl/opc_defines.vh
// Register offsets, field positions, reset values and codes of the opamp pair
// configuration bank.
// Assumes a classic Wishbone slave with 32-bit data and byte addressing.
//
// Operation
// - The first amplifier's two control bytes sit at peripheral addresses 0C0h and 0C1h.
// - The second amplifier's two control bytes sit at 0C2h and 0C3h, the switch control at 0CFh.
// - All bits of the five registers are read/write and clear to zero on power-up clear.
// - Control byte 0 holds inverting select 7-6, non-inverting select 5-4, power mode 3-2.
// - Control byte 1 holds function code 4-2 and calibration enable in bit 1.
// - A force pair of 01 presents inverting select 00 and function 110; 00 forces nothing.
// - A force pair of 10 presents inverting select 01 and function 110; bits 5-4 amp1, 1-0 amp0.
`ifndef OPC_DEFINES_VH
`define OPC_DEFINES_VH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define OPC_IDX_AMP0_CTL0   8'hC0
`define OPC_IDX_AMP0_CTL1   8'hC1
`define OPC_IDX_AMP1_CTL0   8'hC2
`define OPC_IDX_AMP1_CTL1   8'hC3
`define OPC_IDX_SWITCH      8'hCF
`define OPC_ADDR_W          10

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define OPC_RST_VAL         8'h00

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define OPC_INV_HI          7
`define OPC_INV_LO          6
`define OPC_NINV_HI         5
`define OPC_NINV_LO         4
`define OPC_PWR_HI          3
`define OPC_PWR_LO          2
`define OPC_FC_HI           4
`define OPC_FC_LO           2
`define OPC_CAL_BIT         1
`define OPC_FRC0_HI         1
`define OPC_FRC0_LO         0
`define OPC_FRC1_HI         5
`define OPC_FRC1_LO         4

// ----------------------------------------------------------------------------
// Codes
// ----------------------------------------------------------------------------
`define OPC_FRC_NONE        2'h0
`define OPC_FRC_PIN1        2'h1
`define OPC_FRC_PIN2        2'h2
`define OPC_INV_PIN1        2'h0
`define OPC_INV_PIN2        2'h1
`define OPC_FC_INV_AMP      3'h6

`endif

// File: rtl/opc_reg8.v
// One byte-wide read/write configuration register.
// Assumes write strobe already decoded by the bus slave.
`timescale 1ns/10ps
`default_nettype none
`include "opc_defines.vh"
module opc_reg8 (
    // Clock and reset
    input  wire       clk_i,
    input  wire       rst_i,
    // Write port
    input  wire       we_i,
    input  wire [7:0] wdata_i,
    // Stored value
    output reg  [7:0] q_o
);
    always @(posedge clk_i) begin
        if (rst_i) begin
            q_o <= `OPC_RST_VAL;
        end else if (we_i) begin
            q_o <= wdata_i;
        end
    end
endmodule
`default_nettype wire

// File: rtl/opc_force.v
// Applies a switch-control force pair to one amplifier's inverting select
// and function code.
// Assumes combinational use; the caller registers the results.
`timescale 1ns/10ps
`default_nettype none
`include "opc_defines.vh"
module opc_force (
    // Stored selections
    input  wire [1:0] frc_i,
    input  wire [1:0] inv_i,
    input  wire [2:0] fc_i,
    // Effective selections
    output reg  [1:0] inv_o,
    output reg  [2:0] fc_o
);
    always @* begin
        inv_o = inv_i;
        fc_o  = fc_i;
        case (frc_i)
            `OPC_FRC_PIN1: begin
                inv_o = `OPC_INV_PIN1;
                fc_o  = `OPC_FC_INV_AMP;
            end
            `OPC_FRC_PIN2: begin
                inv_o = `OPC_INV_PIN2;
                fc_o  = `OPC_FC_INV_AMP;
            end
            default: begin
                inv_o = inv_i;
                fc_o  = fc_i;
            end
        endcase
    end
endmodule
`default_nettype wire

// File: rtl/opc_top.v
// Opamp pair configuration bank: five byte registers behind a classic
// Wishbone slave, with registered effective control outputs.
// Assumes a single 10 MHz clock and a synchronous active-high reset.
//
// Chosen here: register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
`include "opc_defines.vh"
module opc_top (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [31:0] wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // Amplifier 0 effective controls
    output reg  [1:0]  amp0_inverting_input_select_o,
    output reg  [1:0]  amp0_noninverting_input_select_o,
    output reg  [1:0]  amp0_power_mode_select_o,
    output reg  [2:0]  amp0_function_code_o,
    output reg         amp0_calibration_enable_o,
    // Amplifier 1 effective controls
    output reg  [1:0]  amp1_inverting_input_select_o,
    output reg  [1:0]  amp1_noninverting_input_select_o,
    output reg  [1:0]  amp1_power_mode_select_o,
    output reg  [2:0]  amp1_function_code_o,
    output reg         amp1_calibration_enable_o,
    // Routing switches
    output reg  [7:0]  routing_switch_control_o
);
    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    localparam NREG = 5;
    wire       req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire [7:0] idx   = wb_adr_i[9:2];
    wire       upper = |wb_adr_i[31:10];
    wire       wr    = req & wb_we_i & wb_sel_i[0];
    wire [8*NREG-1:0] idx_tab = {`OPC_IDX_SWITCH, `OPC_IDX_AMP1_CTL1,
                                 `OPC_IDX_AMP1_CTL0, `OPC_IDX_AMP0_CTL1,
                                 `OPC_IDX_AMP0_CTL0};
    wire [8*NREG-1:0] q_all;
    wire [NREG-1:0]   hit;

    genvar g;
    generate
        for (g = 0; g < NREG; g = g + 1) begin : g_reg
            assign hit[g] = ~upper & (idx == idx_tab[8*g+7:8*g]);
            opc_reg8 u_reg (
                .clk_i   (clk_i),
                .rst_i   (rst_i),
                .we_i    (wr & hit[g]),
                .wdata_i (wb_dat_i[7:0]),
                .q_o     (q_all[8*g+7:8*g])
            );
        end
    endgenerate

    wire [7:0] a0c0 = q_all[7:0];
    wire [7:0] a0c1 = q_all[15:8];
    wire [7:0] a1c0 = q_all[23:16];
    wire [7:0] a1c1 = q_all[31:24];
    wire [7:0] swc  = q_all[39:32];

    // ------------------------------------------------------------------------
    // Read mux: stored contents, unaffected by forcing
    // ------------------------------------------------------------------------
    reg [7:0] rd_d;
    integer k;
    always @* begin
        rd_d = 8'h00;
        for (k = 0; k < NREG; k = k + 1) begin
            if (hit[k]) begin
                rd_d = q_all[8*k+:8];
            end
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= req ? {24'h00_0000, rd_d} : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------------
    // Forcing and effective outputs
    // ------------------------------------------------------------------------
    wire [1:0] inv0_eff;
    wire [2:0] fc0_eff;
    wire [1:0] inv1_eff;
    wire [2:0] fc1_eff;

    opc_force u_frc0 (
        .frc_i (swc[`OPC_FRC0_HI:`OPC_FRC0_LO]),
        .inv_i (a0c0[`OPC_INV_HI:`OPC_INV_LO]),
        .fc_i  (a0c1[`OPC_FC_HI:`OPC_FC_LO]),
        .inv_o (inv0_eff),
        .fc_o  (fc0_eff)
    );

    opc_force u_frc1 (
        .frc_i (swc[`OPC_FRC1_HI:`OPC_FRC1_LO]),
        .inv_i (a1c0[`OPC_INV_HI:`OPC_INV_LO]),
        .fc_i  (a1c1[`OPC_FC_HI:`OPC_FC_LO]),
        .inv_o (inv1_eff),
        .fc_o  (fc1_eff)
    );

    always @(posedge clk_i) begin
        if (rst_i) begin
            amp0_inverting_input_select_o    <= 2'h0;
            amp0_noninverting_input_select_o <= 2'h0;
            amp0_power_mode_select_o         <= 2'h0;
            amp0_function_code_o             <= 3'h0;
            amp0_calibration_enable_o        <= 1'b0;
            amp1_inverting_input_select_o    <= 2'h0;
            amp1_noninverting_input_select_o <= 2'h0;
            amp1_power_mode_select_o         <= 2'h0;
            amp1_function_code_o             <= 3'h0;
            amp1_calibration_enable_o        <= 1'b0;
            routing_switch_control_o         <= 8'h00;
        end else begin
            amp0_inverting_input_select_o    <= inv0_eff;
            amp0_noninverting_input_select_o <= a0c0[`OPC_NINV_HI:`OPC_NINV_LO];
            amp0_power_mode_select_o         <= a0c0[`OPC_PWR_HI:`OPC_PWR_LO];
            amp0_function_code_o             <= fc0_eff;
            amp0_calibration_enable_o        <= a0c1[`OPC_CAL_BIT];
            amp1_inverting_input_select_o    <= inv1_eff;
            amp1_noninverting_input_select_o <= a1c0[`OPC_NINV_HI:`OPC_NINV_LO];
            amp1_power_mode_select_o         <= a1c0[`OPC_PWR_HI:`OPC_PWR_LO];
            amp1_function_code_o             <= fc1_eff;
            amp1_calibration_enable_o        <= a1c1[`OPC_CAL_BIT];
            routing_switch_control_o         <= swc;
        end
    end
endmodule
`default_nettype wire

// File: dv/opc_top_sva.sv
// Checker for the opamp pair configuration bank.
// Assumes it is bound to opc_top and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module opc_top_sva (
    input wire logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
    input wire logic [31:0] wb_adr_i, wb_dat_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [1:0]  amp0_inverting_input_select_o, amp1_inverting_input_select_o,
    input wire logic [1:0]  amp0_noninverting_input_select_o, amp0_power_mode_select_o,
    input wire logic [2:0]  amp0_function_code_o, amp1_function_code_o,
    input wire logic        amp0_calibration_enable_o,
    input wire logic [7:0]  routing_switch_control_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_wr(a);
        s_take ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == a);
    endsequence
    AST_ACK: assert property (s_take |=> wb_ack_o)
        else $error("request not answered");
    AST_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_RST: assert property ($fell(rst_i) |-> routing_switch_control_o == 8'h00
        && amp0_function_code_o == 3'h0 && amp0_inverting_input_select_o == 2'h0)
        else $error("outputs not clear after reset");
    AST_SW: assert property (s_wr(32'h33C) |-> ##2
        routing_switch_control_o == $past(wb_dat_i[7:0], 2)) else $error("switch write lost");
    AST_CTL0: assert property (s_wr(32'h300) |-> ##2 {amp0_noninverting_input_select_o,
        amp0_power_mode_select_o} == $past(wb_dat_i[5:2], 2)) else $error("ctl0 fields wrong");
    AST_CTL1: assert property (s_wr(32'h304) |-> ##2
        amp0_calibration_enable_o == $past(wb_dat_i[1], 2)) else $error("calibration wrong");
    AST_F0A: assert property (routing_switch_control_o[1:0] == 2'h1 |->
        amp0_inverting_input_select_o == 2'h0 && amp0_function_code_o == 3'h6)
        else $error("amp0 force 01 wrong");
    AST_F0B: assert property (routing_switch_control_o[1:0] == 2'h2 |->
        amp0_inverting_input_select_o == 2'h1 && amp0_function_code_o == 3'h6)
        else $error("amp0 force 10 wrong");
    AST_F1A: assert property (routing_switch_control_o[5:4] == 2'h1 |->
        amp1_inverting_input_select_o == 2'h0 && amp1_function_code_o == 3'h6)
        else $error("amp1 force 01 wrong");
    AST_F1B: assert property (routing_switch_control_o[5:4] == 2'h2 |->
        amp1_inverting_input_select_o == 2'h1 && amp1_function_code_o == 3'h6)
        else $error("amp1 force 10 wrong");
endmodule
bind opc_top opc_top_sva i_sva (.*);
`default_nettype wire

// File: dv/test_opamp_pair_config_registers.sv
// Self-checking bench for the opamp pair configuration bank.
// Assumes opc_top answers each Wishbone cycle with a one-cycle ack.
`timescale 1ns/10ps
`default_nettype none
module test_opamp_pair_config_registers;
    logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, q;
    logic [3:0]  wb_sel_i = 4'h0;
    wire  [31:0] wb_dat_o;
    wire         wb_ack_o, amp0_calibration_enable_o, amp1_calibration_enable_o;
    wire  [1:0]  amp0_inverting_input_select_o, amp1_inverting_input_select_o;
    wire  [1:0]  amp0_noninverting_input_select_o, amp1_noninverting_input_select_o;
    wire  [1:0]  amp0_power_mode_select_o, amp1_power_mode_select_o;
    wire  [2:0]  amp0_function_code_o, amp1_function_code_o;
    wire  [7:0]  routing_switch_control_o;
    wire  [9:0]  a0 = {amp0_inverting_input_select_o, amp0_noninverting_input_select_o,
                       amp0_power_mode_select_o, amp0_function_code_o, amp0_calibration_enable_o};
    wire  [9:0]  a1 = {amp1_inverting_input_select_o, amp1_noninverting_input_select_o,
                       amp1_power_mode_select_o, amp1_function_code_o, amp1_calibration_enable_o};
    int          failures = 0, checks_done = 0, cycles = 0;
    logic [11:0] adr_t [5] = '{12'h300, 12'h304, 12'h308, 12'h30C, 12'h33C};
    logic [7:0]  val_t [5] = '{8'hE5, 8'hAA, 8'h5A, 8'h47, 8'hCC};
    opc_top i_dut (.*);
    initial forever #50 clk_i = ~clk_i;
    task tally_and_finish;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // One classic cycle; the request holds until ack is sampled
    task bus(input logic w, input logic [11:0] a, input logic [7:0] d, input logic s);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= {20'h0, a};
        wb_dat_i <= {24'h0, d};
        wb_sel_i <= {3'h0, s};
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // --------------------------------
    // Tests
    // --------------------------------
    task t_reset;
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, adr_t[i], 8'h00, 1'b1);
            chk(q, 32'h0);
        end
        chk({4'h0, a1, a0, routing_switch_control_o}, 32'h0);
        $display("test reset values done");
    endtask
    task t_rw;
        for (int i = 0; i < 5; i++) bus(1'b1, adr_t[i], val_t[i], 1'b1);
        bus(1'b1, 12'h310, 8'hFF, 1'b1);
        bus(1'b1, 12'h300, 8'h00, 1'b0);
        bus(1'b1, 12'h700, 8'hFF, 1'b1);
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, adr_t[i], 8'h00, 1'b1);
            chk(q, {24'h0, val_t[i]});
        end
        bus(1'b0, 12'h310, 8'h00, 1'b1);
        chk(q, 32'h0);
        bus(1'b0, 12'h700, 8'h00, 1'b1);
        chk(q, 32'h0);
        chk({12'h0, a0, a1}, {12'h0, 10'h395, 10'h163});
        chk({24'h0, routing_switch_control_o}, 32'hCC);
        $display("test read write done");
    endtask
    task t_force;
        logic [1:0] r;
        logic [4:0] e;
        for (int p = 0; p < 4; p++) begin
            r = 2'h3 - p[1:0];
            bus(1'b1, 12'h33C, {2'h0, r, 2'h0, p[1:0]}, 1'b1);
            @(posedge clk_i);
            e = (p == 1 || p == 2) ? {p[1:0] - 2'h1, 3'h6} : 5'h1A;
            chk({27'h0, a0[9:8], a0[3:1]}, {27'h0, e});
            e = (r == 2'h1 || r == 2'h2) ? {r - 2'h1, 3'h6} : 5'h09;
            chk({27'h0, a1[9:8], a1[3:1]}, {27'h0, e});
            bus(1'b0, 12'h300, 8'h00, 1'b1);
            chk(q, 32'hE5);
            bus(1'b0, 12'h30C, 8'h00, 1'b1);
            chk(q, 32'h47);
        end
        $display("test forcing done");
    endtask
    // Every bit set, then a reset in mid-run must clear all of them
    task t_ones_reset;
        for (int i = 0; i < 5; i++) bus(1'b1, adr_t[i], 8'hFF, 1'b1);
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, adr_t[i], 8'h00, 1'b1);
            chk(q, 32'hFF);
        end
        chk({4'h0, a1, a0, routing_switch_control_o}, 32'h0FFF_FFFF);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({4'h0, a1, a0, routing_switch_control_o}, 32'h0);
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, adr_t[i], 8'h00, 1'b1);
            chk(q, 32'h0);
        end
        $display("test ones and reset done");
    endtask
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            failures++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset;
        t_rw;
        t_force;
        t_ones_reset;
        tally_and_finish;
    end
endmodule
`default_nettype wire
